// ### logic/pport_pkg.sv
/*
 * constants shared by the parallel port control block: register indices,
 * control field positions, reset values and handshake cycle counts.
 * assumes a single 50 MHz core clock and an 8-bit register port.
 */
package pport_pkg;

    // ------------------------------------------------------------
    // register indices on the register port
    // ------------------------------------------------------------
    localparam int         ADDR_W       = 4;
    localparam logic [3:0] OFF_GEN_CTRL = 4'h0;
    localparam logic [3:0] OFF_STATUS   = 4'h1;
    localparam logic [3:0] OFF_CTRL_A   = 4'h2;  // port b at +1
    localparam logic [3:0] OFF_DDR_A    = 4'h4;  // port b at +1
    localparam logic [3:0] OFF_DATA_A   = 4'h6;  // port b at +1
    localparam logic [3:0] OFF_ALT_A    = 4'h8;  // port b at +1

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] GEN_RESET    = 8'h00;
    localparam logic [7:0] DDR_RESET    = 8'h00;

    // ------------------------------------------------------------
    // port control field positions
    // ------------------------------------------------------------
    localparam int SUB_HI       = 7;
    localparam int SUB_LO       = 6;
    localparam int FN_HI        = 5;
    localparam int FN_LO        = 3;
    localparam int AUX_IE_BIT   = 2;
    localparam int SVC_BIT      = 1;

    // ------------------------------------------------------------
    // general control field positions (sense bits 2p strobe, 2p+1 aux)
    // ------------------------------------------------------------
    localparam int GEN_EN_A     = 4;  // port b enable at +1
    localparam int GEN_DMA_EN   = 6;
    localparam int GEN_DMA_SEL  = 7;

    // ------------------------------------------------------------
    // submodes, aux pin functions and counts
    // ------------------------------------------------------------
    localparam logic [1:0] SUB_DBL_IN   = 2'h0;
    localparam logic [1:0] SUB_DBL_OUT  = 2'h1;
    localparam logic [2:0] FN_ASSERTED  = 3'h5;
    localparam logic [2:0] FN_PULSED    = 3'h7;
    localparam logic [2:0] PULSE_CYC    = 3'h4;
    localparam logic [1:0] DMA_CYC      = 2'h3;

endpackage : pport_pkg

// ### logic/pport_ctrl.sv
/*
 * port a and b control logic for the unidirectional 8-bit mode:
 * control registers, double-buffered input with aux pin options,
 * direction-steered data paths, alternate pin reads, service requests.
 * assumes pins and the register port are synchronous to CORE_CLK
 * except strobe and aux inputs, which are synchronised here.
 */
`timescale 1ns/1ps

module pport_ctrl
    import pport_pkg::*;
(
    input  wire logic              CORE_CLK,
    input  wire logic              RST,
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    input  wire logic [7:0]        REG_WDATA,
    output logic      [7:0]        REG_RDATA,
    input  wire logic [7:0]        PORT_A_DATA_IN,
    output logic      [7:0]        PORT_A_DATA_OUT,
    output logic      [7:0]        PORT_A_DATA_OE,
    input  wire logic [7:0]        PORT_B_DATA_IN,
    output logic      [7:0]        PORT_B_DATA_OUT,
    output logic      [7:0]        PORT_B_DATA_OE,
    input  wire logic              PORT_A_STROBE_PIN,
    input  wire logic              PORT_A_AUX_PIN_IN,
    output logic                   PORT_A_AUX_PIN_OUT,
    output logic                   PORT_A_AUX_PIN_OE,
    input  wire logic              PORT_B_STROBE_PIN,
    input  wire logic              PORT_B_AUX_PIN_IN,
    output logic                   PORT_B_AUX_PIN_OUT,
    output logic                   PORT_B_AUX_PIN_OE,
    output logic                   PORT_IRQ,
    output logic                   DMA_REQUEST_PIN
);

    // ------------------------------------------------------------
    // shared state and per-port views
    // ------------------------------------------------------------
    logic [7:0] gen_ctrl_r;
    logic [7:0] rdata_r;
    logic       irq_r;
    logic       dma_r;
    logic [1:0] dma_cnt_r;
    logic [7:0] pin_in    [2];
    logic       stb_pin   [2];
    logic       aux_in    [2];
    logic [7:0] ctrl_w    [2];
    logic [7:0] ddr_w     [2];
    logic [7:0] fol_w     [2];
    logic [7:0] dread_w   [2];
    logic       aux_out_w [2];
    logic       aux_oe_w  [2];
    logic [3:0] status_w;
    logic [1:0] irq_w;
    logic [1:0] dma_trig_w;

    assign pin_in[0]          = PORT_A_DATA_IN;
    assign pin_in[1]          = PORT_B_DATA_IN;
    assign stb_pin[0]         = PORT_A_STROBE_PIN;
    assign stb_pin[1]         = PORT_B_STROBE_PIN;
    assign aux_in[0]          = PORT_A_AUX_PIN_IN;
    assign aux_in[1]          = PORT_B_AUX_PIN_IN;
    assign PORT_A_DATA_OUT    = fol_w[0];
    assign PORT_B_DATA_OUT    = fol_w[1];
    assign PORT_A_DATA_OE     = ddr_w[0];
    assign PORT_B_DATA_OE     = ddr_w[1];
    assign PORT_A_AUX_PIN_OUT = aux_out_w[0];
    assign PORT_B_AUX_PIN_OUT = aux_out_w[1];
    assign PORT_A_AUX_PIN_OE  = aux_oe_w[0];
    assign PORT_B_AUX_PIN_OE  = aux_oe_w[1];
    assign REG_RDATA          = rdata_r;
    assign PORT_IRQ           = irq_r;
    assign DMA_REQUEST_PIN    = dma_r;

    // general control: enables, sense bits, dma routing
    // sense bits reset
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            gen_ctrl_r <= GEN_RESET;
        else if (REG_WR && REG_ADDR == OFF_GEN_CTRL)
            gen_ctrl_r <= REG_WDATA;
    end

    // ------------------------------------------------------------
    // per-port logic
    // ------------------------------------------------------------
    for (genvar p = 0; p < 2; p++)
    begin : g_port
        logic [7:0] ctrl_r, ddr_r, fol_r, iol_r, il_r, fil_r;
        logic       fol_full_r, iol_full_r, il_full_r, fil_full_r;
        logic [2:0] stb_sync_r, aux_sync_r;
        logic       asrt_r, armed_r, aux_flag_r, aux_pin_r, aux_oe_r;
        logic [2:0] cnt_r;
        logic       asrt_nxt, armed_nxt;
        logic [2:0] cnt_nxt;
        logic       en, stb_sense, aux_sense, stb_edge, aux_edge;
        logic       sub_in, sub_out, hs_fn, room, accept, take, pop;
        logic       wr_data, rd_data, wr_stat;
        logic [1:0] sub;
        logic [2:0] fn;

        assign en        = gen_ctrl_r[GEN_EN_A + p];
        assign stb_sense = gen_ctrl_r[2*p];
        assign aux_sense = gen_ctrl_r[2*p + 1];
        assign sub       = ctrl_r[SUB_HI:SUB_LO];
        assign fn        = ctrl_r[FN_HI:FN_LO];
        assign sub_in    = (sub == SUB_DBL_IN);
        assign sub_out   = (sub == SUB_DBL_OUT);
        assign hs_fn     = fn[2] & fn[1];
        assign room      = ~(il_full_r & fil_full_r);
        assign wr_data   = REG_WR && REG_ADDR == OFF_DATA_A + 4'(p);
        assign rd_data   = REG_RD && REG_ADDR == OFF_DATA_A + 4'(p);
        assign wr_stat   = REG_WR && REG_ADDR == OFF_STATUS
                           && REG_WDATA[2*p + 1];

        // edges taken from synchronised stages only, sense applied
        // asserted level
        // sense 0 means asserted low, so the pin is xor-ed with ~sense
        assign stb_edge = ~(stb_sync_r[1] ^ stb_sense)
                          & (stb_sync_r[2] ^ stb_sense);
        assign aux_edge = ~(aux_sync_r[1] ^ aux_sense)
                          & (aux_sync_r[2] ^ aux_sense);

        // strobe capture; with a handshake aux function, ignored until armed
        assign accept = en & sub_in & stb_edge & (~hs_fn | armed_r);
        // peripheral takes the output latch in the double-buffered output
        assign take   = en & sub_out & stb_edge & fol_full_r;
        assign pop    = rd_data & sub_in & fil_full_r;

        // two-stage synchronisers, third stage for edges
        always_ff @(posedge CORE_CLK or posedge RST)
        begin
            if (RST)
            begin
                stb_sync_r <= 3'h0;
                aux_sync_r <= 3'h0;
            end
            else
            begin
                stb_sync_r <= {stb_sync_r[1:0], stb_pin[p]};
                aux_sync_r <= {aux_sync_r[1:0], aux_in[p]};
            end
        end

        // control register; read has no effect
        // field layout fixed by the constants above
        always_ff @(posedge CORE_CLK or posedge RST)
        begin
            if (RST)
                ctrl_r <= CTRL_RESET;
            else if (REG_WR && REG_ADDR == OFF_CTRL_A + 4'(p))
                ctrl_r <= REG_WDATA;
        end

        // direction register
        always_ff @(posedge CORE_CLK or posedge RST)
        begin
            if (RST)
                ddr_r <= DDR_RESET;
            else if (REG_WR && REG_ADDR == OFF_DDR_A + 4'(p))
                ddr_r <= REG_WDATA;
        end

        // output latches; a write touches handshake state only in enabled double-buffered output
        // single or double buffered; single latch
        always_ff @(posedge CORE_CLK or posedge RST)
        begin
            if (RST)
            begin
                fol_r      <= 8'h00;
                iol_r      <= 8'h00;
                fol_full_r <= 1'b0;
                iol_full_r <= 1'b0;
            end
            else if (!sub_out)
            begin
                fol_full_r <= 1'b0;
                iol_full_r <= 1'b0;
                if (wr_data)
                    fol_r <= REG_WDATA;
            end
            else if (!en)
            begin
                fol_full_r <= 1'b0;
                iol_full_r <= 1'b0;
                if (wr_data)
                    fol_r <= REG_WDATA;
            end
            else if (take)
            begin
                fol_full_r <= iol_full_r | wr_data;
                iol_full_r <= 1'b0;
                if (iol_full_r)
                    fol_r <= iol_r;
                else if (wr_data)
                    fol_r <= REG_WDATA;
                if (iol_full_r && wr_data)
                begin
                    iol_r      <= REG_WDATA;
                    iol_full_r <= 1'b1;
                end
            end
            else if (wr_data)
            begin
                if (!fol_full_r)
                begin
                    fol_r      <= REG_WDATA;
                    fol_full_r <= 1'b1;
                end
                else
                begin
                    iol_r      <= REG_WDATA;   // newest write wins
                    iol_full_r <= 1'b1;
                end
            end
        end

        // double-buffered input: fil is read first, il backs it up
        // disabled means empty
        always_ff @(posedge CORE_CLK or posedge RST)
        begin
            if (RST)
            begin
                il_r       <= 8'h00;
                fil_r      <= 8'h00;
                il_full_r  <= 1'b0;
                fil_full_r <= 1'b0;
            end
            else if (!en || !sub_in)
            begin
                il_full_r  <= 1'b0;
                fil_full_r <= 1'b0;
            end
            else
            begin
                case ({pop, accept})
                    2'b10:
                    begin
                        fil_r      <= il_r;
                        fil_full_r <= il_full_r;
                        il_full_r  <= 1'b0;
                    end
                    2'b01:
                    begin
                        if (!fil_full_r)
                        begin
                            fil_r      <= pin_in[p];
                            fil_full_r <= 1'b1;
                        end
                        else if (!il_full_r)
                        begin
                            il_r      <= pin_in[p];
                            il_full_r <= 1'b1;
                        end
                    end
                    2'b11:
                    begin
                        fil_full_r <= 1'b1;
                        if (il_full_r)
                        begin
                            fil_r <= il_r;
                            il_r  <= pin_in[p];
                        end
                        else
                            fil_r <= pin_in[p];
                    end
                    default:
                    begin
                        fil_full_r <= fil_full_r;
                    end
                endcase
            end
        end

        // aux pin next state; hardware cannot negate asynchronously,
        // so the strobe edge negates it on the edge-detect cycle
        always_comb
        begin
            asrt_nxt  = 1'b0;
            armed_nxt = 1'b0;
            cnt_nxt   = 3'h0;
            if (!fn[2])
                asrt_nxt = 1'b0;
            else if (!hs_fn)
                asrt_nxt = (fn == FN_ASSERTED);
            else if (!en || !sub_in || !room || accept)
                asrt_nxt = 1'b0;
            else if (!armed_r)
            begin
                asrt_nxt  = 1'b1;
                armed_nxt = 1'b1;
                cnt_nxt   = 3'h1;
            end
            else
            begin
                armed_nxt = 1'b1;
                asrt_nxt  = asrt_r;
                cnt_nxt   = cnt_r;
                if (cnt_r < PULSE_CYC)
                    cnt_nxt = cnt_r + 3'h1;
                else if (fn == FN_PULSED)
                    asrt_nxt = 1'b0;
            end
        end

        // aux pin registers, level includes the sense bit
        // 0XX is an input, else driven
        always_ff @(posedge CORE_CLK or posedge RST)
        begin
            if (RST)
            begin
                asrt_r    <= 1'b0;
                armed_r   <= 1'b0;
                cnt_r     <= 3'h0;
                aux_pin_r <= 1'b0;
                aux_oe_r  <= 1'b0;
            end
            else
            begin
                asrt_r    <= asrt_nxt;
                armed_r   <= armed_nxt;
                cnt_r     <= cnt_nxt;
                aux_pin_r <= ~(asrt_nxt ^ aux_sense);
                aux_oe_r  <= fn[2];
            end
        end

        // aux status flag; a new edge beats a same-cycle clear write
        // status input flag; clear otherwise
        always_ff @(posedge CORE_CLK or posedge RST)
        begin
            if (RST)
                aux_flag_r <= 1'b0;
            else if (!en || fn[2])
                aux_flag_r <= 1'b0;
            else if (aux_edge)
                aux_flag_r <= 1'b1;
            else if (wr_stat)
                aux_flag_r <= 1'b0;
        end

        assign status_w[2*p]     = sub_in & fil_full_r;
        assign status_w[2*p + 1] = aux_flag_r;

        // request gating; dma-routed strobe leaves the irq
        assign irq_w[p] = (aux_flag_r & ctrl_r[AUX_IE_BIT])
                          | (status_w[2*p] & ctrl_r[SVC_BIT]
                             & ~(gen_ctrl_r[GEN_DMA_EN]
                                 & gen_ctrl_r[GEN_DMA_SEL] == 1'(p)));
        // one port, never in bit i/o
        assign dma_trig_w[p] = (accept | take) & ctrl_r[SVC_BIT]
                               & ~ctrl_r[SUB_HI]
                               & gen_ctrl_r[GEN_DMA_EN]
                               & (gen_ctrl_r[GEN_DMA_SEL] == 1'(p));

        assign dread_w[p] = (ddr_r & fol_r)
                            | (~ddr_r & (sub_in ? fil_r : pin_in[p]));
        assign ctrl_w[p]    = ctrl_r;
        assign ddr_w[p]     = ddr_r;   // driver enable
        assign fol_w[p]     = fol_r;
        assign aux_out_w[p] = aux_pin_r;
        assign aux_oe_w[p]  = aux_oe_r;
    end

    // ------------------------------------------------------------
    // register read, request outputs
    // ------------------------------------------------------------

    // read data registered one cycle after REG_RD; unmapped reads zero
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            rdata_r <= 8'h00;
        else if (REG_RD)
        begin
            case (REG_ADDR)
                OFF_GEN_CTRL:    rdata_r <= gen_ctrl_r;
                OFF_STATUS:      rdata_r <= {4'h0, status_w};
                OFF_CTRL_A:      rdata_r <= ctrl_w[0];
                OFF_CTRL_A+4'h1: rdata_r <= ctrl_w[1];
                OFF_DDR_A:       rdata_r <= ddr_w[0];
                OFF_DDR_A+4'h1:  rdata_r <= ddr_w[1];
                OFF_DATA_A:      rdata_r <= dread_w[0];
                OFF_DATA_A+4'h1: rdata_r <= dread_w[1];
                OFF_ALT_A:       rdata_r <= pin_in[0];
                OFF_ALT_A+4'h1:  rdata_r <= pin_in[1];
                default:         rdata_r <= 8'h00;
            endcase
        end
    end

    // one request line shared by both ports
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            irq_r <= 1'b0;
        else
            irq_r <= |irq_w;
    end

    // dma pulse of fixed length; a retrigger restarts it
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            dma_r     <= 1'b0;
            dma_cnt_r <= 2'h0;
        end
        else if (|dma_trig_w)
        begin
            dma_r     <= 1'b1;
            dma_cnt_r <= DMA_CYC - 2'h1;
        end
        else if (dma_cnt_r != 2'h0)
            dma_cnt_r <= dma_cnt_r - 2'h1;
        else
            dma_r <= 1'b0;
    end

endmodule : pport_ctrl

// ### tb/pport_periph.sv
/* peripheral model on the far side of port a: drives data and strobe.
   assumes active-low handshake sense and a shared core clock. */
`timescale 1ns/1ps
module pport_periph (
    input  wire logic       CLK,
    input  wire logic       AUX_OUT,
    output logic      [7:0] DATA,
    output logic            STROBE,
    output logic            AUX_IN
);
    // idle levels: strobe and aux negated
    initial
    begin
        DATA = 8'h00;
        STROBE = 1'b1;
        AUX_IN = 1'b1;
    end

    task automatic send(input logic [7:0] b, input logic rdy);
        int i;
        i = 0;
        while (rdy && AUX_OUT !== 1'b0 && i < 50)
        begin
            @(negedge CLK);
            i++;
        end
        @(negedge CLK);
        DATA = b;
        @(negedge CLK);
        STROBE = 1'b0;
        repeat (5) @(negedge CLK);
        DATA = ~b;  // released bus must not keep the old byte
        STROBE = 1'b1;
        repeat (5) @(negedge CLK);
    endtask : send

    // one asserted edge on the aux status input
    task automatic pulse_aux;
        @(negedge CLK);
        AUX_IN = 1'b0;
        repeat (5) @(negedge CLK);
        AUX_IN = 1'b1;
        repeat (5) @(negedge CLK);
    endtask : pulse_aux
endmodule : pport_periph

// ### tb/pport_checker.sv
/* port-level checks of the parallel port block, bound to pport_ctrl.
   assumes sense bits stay zero and one register access per cycle. */
`timescale 1ns/1ps
module pport_checker
    import pport_pkg::*;
(
    input wire logic              CORE_CLK,
    input wire logic              RST,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic              REG_WR,
    input wire logic              REG_RD,
    input wire logic [7:0]        REG_WDATA,
    input wire logic [7:0]        REG_RDATA,
    input wire logic [7:0]        PORT_A_DATA_IN,
    input wire logic [7:0]        PORT_A_DATA_OUT,
    input wire logic [7:0]        PORT_A_DATA_OE,
    input wire logic              PORT_A_AUX_PIN_OUT,
    input wire logic              PORT_A_AUX_PIN_OE,
    input wire logic              DMA_REQUEST_PIN
);
    logic [7:0] ctrl_a_r;
    logic [7:0] gen_r;
    logic       aux_on;

    // shadow of control writes: the aux function is not visible otherwise
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            ctrl_a_r <= CTRL_RESET;
            gen_r    <= GEN_RESET;
        end
        else if (REG_WR && REG_ADDR == OFF_CTRL_A)
            ctrl_a_r <= REG_WDATA;
        else if (REG_WR && REG_ADDR == OFF_GEN_CTRL)
            gen_r <= REG_WDATA;
    end
    assign aux_on = PORT_A_AUX_PIN_OUT ^ ~gen_r[1];

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    alt_read_a: assert property (
        REG_RD && REG_ADDR == OFF_ALT_A |=>
        REG_RDATA == $past(PORT_A_DATA_IN)) else $error("alt read wrong");
    ctrl_read_a: assert property (
        REG_RD && REG_ADDR == OFF_CTRL_A |=>
        REG_RDATA == $past(ctrl_a_r)) else $error("ctrl read wrong");
    dir_oe_a: assert property (
        REG_WR && REG_ADDR == OFF_DDR_A |=>
        PORT_A_DATA_OE == $past(REG_WDATA)) else $error("oe wrong");
    out_latch_a: assert property (
        REG_WR && REG_ADDR == OFF_DATA_A && ctrl_a_r[7:6] == SUB_DBL_IN |=>
        PORT_A_DATA_OUT == $past(REG_WDATA)) else $error("latch wrong");
    dma_pulse_a: assert property (
        $rose(DMA_REQUEST_PIN) |-> DMA_REQUEST_PIN[*3] ##1 !DMA_REQUEST_PIN)
        else $error("dma pulse length wrong");
    pulse_len_a: assert property (
        (ctrl_a_r[5:3] == FN_PULSED && aux_on)[*4] |=> !aux_on)
        else $error("aux pulse too long");
    aux_off_a: assert property (
        ctrl_a_r[5:4] == 2'h3 && !gen_r[GEN_EN_A] |=>
        !aux_on && PORT_A_AUX_PIN_OE) else $error("aux not held off");
    aux_static_a: assert property (
        ctrl_a_r[5:3] == FN_ASSERTED |=> aux_on && PORT_A_AUX_PIN_OE)
        else $error("aux not asserted");
    aux_neg_a: assert property (
        ctrl_a_r[5:3] == 3'h4 |=> !aux_on) else $error("aux not negated");

    cover_dma_c: cover property ($rose(DMA_REQUEST_PIN));
    cover_pulse_c: cover property (ctrl_a_r[5:3] == FN_PULSED && aux_on);
    cover_alt_c: cover property (REG_RD && REG_ADDR == OFF_ALT_A);
endmodule : pport_checker

bind pport_ctrl pport_checker chk (
    .CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .PORT_A_DATA_IN(PORT_A_DATA_IN),
    .PORT_A_DATA_OUT(PORT_A_DATA_OUT), .PORT_A_DATA_OE(PORT_A_DATA_OE),
    .PORT_A_AUX_PIN_OUT(PORT_A_AUX_PIN_OUT),
    .PORT_A_AUX_PIN_OE(PORT_A_AUX_PIN_OE),
    .DMA_REQUEST_PIN(DMA_REQUEST_PIN));

// ### tb/tb_handshake_parallel_port_mode0.sv
/* register-level tests of the parallel port block with a peripheral.
   assumes the checker is bound and port b pins stay idle. */
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module tb_handshake_parallel_port_mode0
    import pport_pkg::*;
;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, a_in, a_out, a_oe;
    logic       a_stb, peer_aux, a_aux_out, a_aux_oe, irq, dma;
    int         fails = 0, n_tests = 0, cyc = 0, dma_hi = 0;
    wire        a_pin = a_aux_oe ? a_aux_out : peer_aux;

    always #10 core_clk = ~core_clk;

    // dma high cycles, sampled away from the edge that launches them
    always @(negedge core_clk)
        if (dma === 1'b1) dma_hi++;

    pport_ctrl dut (
        .CORE_CLK(core_clk), .RST(rst), .REG_ADDR(reg_addr),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .PORT_A_DATA_IN(a_in),
        .PORT_A_DATA_OUT(a_out), .PORT_A_DATA_OE(a_oe),
        .PORT_B_DATA_IN(8'h00), .PORT_B_DATA_OUT(), .PORT_B_DATA_OE(),
        .PORT_A_STROBE_PIN(a_stb), .PORT_A_AUX_PIN_IN(a_pin),
        .PORT_A_AUX_PIN_OUT(a_aux_out), .PORT_A_AUX_PIN_OE(a_aux_oe),
        .PORT_B_STROBE_PIN(1'b1), .PORT_B_AUX_PIN_IN(1'b1),
        .PORT_B_AUX_PIN_OUT(), .PORT_B_AUX_PIN_OE(),
        .PORT_IRQ(irq), .DMA_REQUEST_PIN(dma));
    pport_periph peer (.CLK(core_clk), .AUX_OUT(a_pin), .DATA(a_in),
        .STROBE(a_stb), .AUX_IN(peer_aux));

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr

    // read data is registered, so it is settled by the next falling edge
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        `CHK(reg_rdata, e)
    endtask : rd

    task automatic test_done;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // hang guard, over twenty times the expected run length
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            test_done();
        end
    end

    initial
    begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        rd(OFF_CTRL_A, CTRL_RESET);
        rd(OFF_CTRL_A + 4'h1, CTRL_RESET);
        wr(OFF_CTRL_A + 4'h1, 8'ha5);
        rd(OFF_CTRL_A + 4'h1, 8'ha5);
        rd(OFF_CTRL_A + 4'h1, 8'ha5);
        wr(OFF_CTRL_A + 4'h1, 8'h00);
        rd(4'hf, 8'h00);
        wr(OFF_DDR_A, 8'hf0);
        wr(OFF_DATA_A, 8'h3c);
        `CHK(a_out, 8'h3c)
        `CHK(a_oe, 8'hf0)
        wr(OFF_DDR_A, 8'h00);
        // interlocked input with dma routed to port a
        wr(OFF_GEN_CTRL, 8'h50);
        wr(OFF_CTRL_A, 8'h32);
        repeat (4) @(negedge core_clk);
        `CHK(a_pin, 1'b0)
        peer.send(8'h11, 1'b1);
        peer.send(8'h22, 1'b1);
        `CHK(a_pin, 1'b1)
        peer.send(8'h33, 1'b0);
        rd(OFF_STATUS, 8'h01);
        `CHK(irq, 1'b0)
        rd(OFF_ALT_A, 8'hcc);
        rd(OFF_DATA_A, 8'h11);
        rd(OFF_DATA_A, 8'h22);
        rd(OFF_STATUS, 8'h00);
        wr(OFF_CTRL_A, 8'h3a);
        peer.send(8'h44, 1'b1);
        rd(OFF_DATA_A, 8'h44);
        `CHK(dma_hi, 9)
        wr(OFF_GEN_CTRL, 8'h00);
        repeat (2) @(negedge core_clk);
        `CHK(a_pin, 1'b1)
        // aux as status input with its interrupt enabled
        // function set while disabled so no handshake pulse feeds back
        wr(OFF_CTRL_A, 8'h04);
        wr(OFF_GEN_CTRL, 8'h10);
        peer.pulse_aux();
        wr(OFF_DATA_A, 8'h77);
        `CHK(a_out, 8'h77)
        rd(OFF_STATUS, 8'h02);
        `CHK(irq, 1'b1)
        wr(OFF_STATUS, 8'h02);
        rd(OFF_STATUS, 8'h00);
        `CHK(irq, 1'b0)
        wr(OFF_CTRL_A, 8'h28);
        @(negedge core_clk);
        `CHK(a_pin, 1'b0)
        wr(OFF_CTRL_A, 8'h20);
        @(negedge core_clk);
        `CHK(a_pin, 1'b1)
        test_done();
    end
endmodule : tb_handshake_parallel_port_mode0
